// [design/rec_pkg.sv]
// constants and carrier types of the reference and excitation config bank
package rec_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0] REC_REF_ADDR  = 8'h05;
  localparam logic [7:0] REC_EXC_ADDR  = 8'h06;
  localparam logic [7:0] REC_REF_RESET = 8'h10;
  localparam logic [7:0] REC_EXC_RESET = 8'h00;

  // ********************************************************
  // field positions, reference control
  // ********************************************************
  localparam int REC_MON_MSB     = 7;
  localparam int REC_MON_LSB     = 6;
  localparam int REC_POS_BYP_BIT = 5;
  localparam int REC_NEG_BYP_BIT = 4;
  localparam int REC_SRC_MSB     = 3;
  localparam int REC_SRC_LSB     = 2;
  localparam int REC_IREF_MSB    = 1;
  localparam int REC_IREF_LSB    = 0;

  // ********************************************************
  // field positions, excitation control
  // ********************************************************
  localparam int REC_RAIL_BIT    = 7;
  localparam int REC_SWITCH_BIT  = 6;
  localparam int REC_MAG_MSB     = 3;
  localparam int REC_MAG_LSB     = 0;

  // ********************************************************
  // field codes
  // ********************************************************
  localparam logic [1:0] REC_MON_OFF       = 2'h0;
  localparam logic [1:0] REC_MON_LOW       = 2'h1;
  localparam logic [1:0] REC_MON_LOW_HIGH  = 2'h2;
  localparam logic [1:0] REC_MON_LOW_PULL  = 2'h3;
  localparam logic [1:0] REC_SRC_PAIR_ZERO = 2'h0;
  localparam logic [1:0] REC_SRC_PAIR_ONE  = 2'h1;
  localparam logic [1:0] REC_SRC_INTERNAL  = 2'h2;
  localparam logic [1:0] REC_IREF_OFF      = 2'h0;
  localparam logic [1:0] REC_IREF_ON_PD    = 2'h1;
  localparam logic [1:0] REC_IREF_ALWAYS   = 2'h2;

  // ********************************************************
  // excitation current table, microamps
  // ********************************************************
  localparam logic [11:0] REC_UA_OFF  = 12'h000;
  localparam logic [11:0] REC_UA_10   = 12'h00A;
  localparam logic [11:0] REC_UA_50   = 12'h032;
  localparam logic [11:0] REC_UA_100  = 12'h064;
  localparam logic [11:0] REC_UA_250  = 12'h0FA;
  localparam logic [11:0] REC_UA_500  = 12'h1F4;
  localparam logic [11:0] REC_UA_750  = 12'h2EE;
  localparam logic [11:0] REC_UA_1000 = 12'h3E8;
  localparam logic [11:0] REC_UA_2000 = 12'h7D0;

  // ********************************************************
  // carrier types
  // ********************************************************
  typedef struct packed {
    logic [1:0] ref_monitor_cfg;
    logic       pos_ref_buffer_bypass;
    logic       neg_ref_buffer_bypass;
    logic [1:0] ref_source_select;
    logic [1:0] internal_ref_control;
  } rec_ref_reg_type;

  typedef struct packed {
    logic       amp_rail_monitor_enable;
    logic       low_side_switch;
    logic [3:0] excitation_magnitude;
  } rec_exc_reg_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rec_bus_req_type;

  typedef struct packed {
    logic        ref_low_monitor;
    logic        ref_high_monitor;
    logic        ref_pull_together;
    logic        pos_ref_buffer_bypass;
    logic        neg_ref_buffer_bypass;
    logic        ext_ref_pair_zero_sel;
    logic        ext_ref_pair_one_sel;
    logic        internal_ref_sel;
    logic        ref_source_reserved;
    logic        internal_ref_on;
    logic        amp_rail_monitor_enable;
    logic        low_side_switch_closed;
    logic [11:0] excitation_source_one_ua;
    logic [11:0] excitation_source_two_ua;
    logic        excitation_without_ref;
    logic        internal_ref_buffered;
  } rec_ctrl_type;

endpackage : rec_pkg

// [design/rec_current_decode.sv]
// excitation magnitude code to microamp value
`timescale 1ns/1ps
`default_nettype none

module rec_current_decode #(
  parameter logic [11:0] UA_CODE8 = 12'h5DC
) (
  // magnitude code in
  input  wire logic [3:0]  code,
  // decoded current out
  output logic      [11:0] current_ua,
  output logic             active
);

  // ********************************************************
  // table lookup
  // ********************************************************
  function automatic logic [11:0] rec_ua_of(input logic [3:0] c);
    logic [11:0] v;
    v = rec_pkg::REC_UA_OFF;
    case (c)
      4'h1:    v = rec_pkg::REC_UA_10;
      4'h2:    v = rec_pkg::REC_UA_50;
      4'h3:    v = rec_pkg::REC_UA_100;
      4'h4:    v = rec_pkg::REC_UA_250;
      4'h5:    v = rec_pkg::REC_UA_500;
      4'h6:    v = rec_pkg::REC_UA_750;
      4'h7:    v = rec_pkg::REC_UA_1000;
      4'h8:    v = UA_CODE8;
      4'h9:    v = rec_pkg::REC_UA_2000;
      default: v = rec_pkg::REC_UA_OFF; // zero and codes above nine are off [RL12]
    endcase
    return v;
  endfunction : rec_ua_of

  // current and activity from the same lookup
  always_comb begin
    current_ua = rec_ua_of(code); // [RL12]
    active     = (rec_ua_of(code) != rec_pkg::REC_UA_OFF);
  end

endmodule : rec_current_decode
`default_nettype wire

// [design/rec_config_regs.sv]
// reference and excitation configuration register bank
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RL1 - reference register at 05h, resets to 10h: negative bypass set, rest zero
// RL2 - bits 7:6 select off, low monitor, low plus high, or low plus pull-together
// RL3 - bit 5: zero keeps positive reference buffer on, one bypasses it
// RL4 - bit 4: zero enables negative buffer, one bypasses it, one after reset
// RL5 - bits 3:2 select pair zero, pair one, internal reference; 11 reserved
// RL6 - bits 1:0: off, on except power-down, always on; 11 reserved
// RL7 - host should set both bypass bits when using the internal reference
// RL8 - host must turn internal reference on before nonzero excitation current
// RL9 - excitation register at 06h resets 00h; bits 5:4 read zero, written zero
// RL10 - bit 7 of excitation register enables the output rail monitor
// RL11 - bit 6 closes low-side switch; power-down forces it open
// RL12 - bits 3:0 give current: zero off, 1 to 9 table, above nine off
// RL13 - one magnitude field drives both excitation sources identically
// RL14 - fields hold last written value; reads return stored values unchanged
module rec_config_regs (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // register port
  input  wire rec_pkg::rec_bus_req_type  bus_req,
  output logic                     [7:0] rdata,
  // device mode
  input  wire logic                      power_down,
  // decoded configuration
  output rec_pkg::rec_ctrl_type          ctrl
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    rec_pkg::rec_ref_reg_type ref_q;
    rec_pkg::rec_exc_reg_type exc_q;
    logic [7:0]               rdata_q;
    rec_pkg::rec_ctrl_type    ctrl_q;
  } rec_state_type;

  rec_state_type state_q;
  rec_state_type state_d;
  logic [11:0]   mag_ua;
  logic          mag_active;
  logic [3:0]    mag_code_d;

  // ********************************************************
  // current decode, shared by both sources
  // ********************************************************
  // next magnitude code, kept apart from state_d so the decode forms no loop
  always_comb begin
    mag_code_d = state_q.exc_q.excitation_magnitude;
    if (bus_req.wr && bus_req.addr == rec_pkg::REC_EXC_ADDR) begin
      mag_code_d = bus_req.wdata[rec_pkg::REC_MAG_MSB:rec_pkg::REC_MAG_LSB]; // [RL13]
    end
  end

  rec_current_decode u_current (
    .code       (mag_code_d),
    .current_ua (mag_ua),
    .active     (mag_active)
  );

  // ********************************************************
  // register read image
  // ********************************************************
  function automatic logic [7:0] rec_ref_image(input rec_pkg::rec_ref_reg_type r);
    logic [7:0] v;
    v = 8'h00;
    v[rec_pkg::REC_MON_MSB:rec_pkg::REC_MON_LSB]   = r.ref_monitor_cfg;
    v[rec_pkg::REC_POS_BYP_BIT]                    = r.pos_ref_buffer_bypass;
    v[rec_pkg::REC_NEG_BYP_BIT]                    = r.neg_ref_buffer_bypass;
    v[rec_pkg::REC_SRC_MSB:rec_pkg::REC_SRC_LSB]   = r.ref_source_select;
    v[rec_pkg::REC_IREF_MSB:rec_pkg::REC_IREF_LSB] = r.internal_ref_control;
    return v;
  endfunction : rec_ref_image

  function automatic logic [7:0] rec_exc_image(input rec_pkg::rec_exc_reg_type e);
    logic [7:0] v;
    v = 8'h00; // reserved bits 5:4 read zero [RL9]
    v[rec_pkg::REC_RAIL_BIT]                     = e.amp_rail_monitor_enable;
    v[rec_pkg::REC_SWITCH_BIT]                   = e.low_side_switch;
    v[rec_pkg::REC_MAG_MSB:rec_pkg::REC_MAG_LSB] = e.excitation_magnitude;
    return v;
  endfunction : rec_exc_image

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    logic iref_on;
    iref_on = 1'b0;
    state_d = state_q;

    // register writes; unmapped addresses are ignored
    if (bus_req.wr && bus_req.addr == rec_pkg::REC_REF_ADDR) begin
      state_d.ref_q.ref_monitor_cfg =
        bus_req.wdata[rec_pkg::REC_MON_MSB:rec_pkg::REC_MON_LSB]; // [RL2] [RL14]
      state_d.ref_q.pos_ref_buffer_bypass =
        bus_req.wdata[rec_pkg::REC_POS_BYP_BIT]; // [RL3]
      state_d.ref_q.neg_ref_buffer_bypass =
        bus_req.wdata[rec_pkg::REC_NEG_BYP_BIT]; // [RL4]
      state_d.ref_q.ref_source_select =
        bus_req.wdata[rec_pkg::REC_SRC_MSB:rec_pkg::REC_SRC_LSB]; // [RL5]
      state_d.ref_q.internal_ref_control =
        bus_req.wdata[rec_pkg::REC_IREF_MSB:rec_pkg::REC_IREF_LSB]; // [RL6]
    end else if (bus_req.wr && bus_req.addr == rec_pkg::REC_EXC_ADDR) begin
      state_d.exc_q.amp_rail_monitor_enable =
        bus_req.wdata[rec_pkg::REC_RAIL_BIT]; // [RL10] [RL14]
      state_d.exc_q.low_side_switch =
        bus_req.wdata[rec_pkg::REC_SWITCH_BIT]; // [RL11]
      state_d.exc_q.excitation_magnitude =
        bus_req.wdata[rec_pkg::REC_MAG_MSB:rec_pkg::REC_MAG_LSB]; // [RL12]
    end

    // read data for one cycle only, stored values as held [RL14]
    state_d.rdata_q = 8'h00;
    if (bus_req.rd && bus_req.addr == rec_pkg::REC_REF_ADDR) begin
      state_d.rdata_q = rec_ref_image(state_q.ref_q);
    end else if (bus_req.rd && bus_req.addr == rec_pkg::REC_EXC_ADDR) begin
      state_d.rdata_q = rec_exc_image(state_q.exc_q); // [RL9]
    end

    // reference monitor decode
    state_d.ctrl_q.ref_low_monitor =
      (state_d.ref_q.ref_monitor_cfg != rec_pkg::REC_MON_OFF); // [RL2]
    state_d.ctrl_q.ref_high_monitor =
      (state_d.ref_q.ref_monitor_cfg == rec_pkg::REC_MON_LOW_HIGH); // [RL2]
    state_d.ctrl_q.ref_pull_together =
      (state_d.ref_q.ref_monitor_cfg == rec_pkg::REC_MON_LOW_PULL); // [RL2]

    // reference buffers
    state_d.ctrl_q.pos_ref_buffer_bypass = state_d.ref_q.pos_ref_buffer_bypass; // [RL3]
    state_d.ctrl_q.neg_ref_buffer_bypass = state_d.ref_q.neg_ref_buffer_bypass; // [RL4]

    // reference source, reserved code selects nothing
    state_d.ctrl_q.ext_ref_pair_zero_sel =
      (state_d.ref_q.ref_source_select == rec_pkg::REC_SRC_PAIR_ZERO); // [RL5]
    state_d.ctrl_q.ext_ref_pair_one_sel =
      (state_d.ref_q.ref_source_select == rec_pkg::REC_SRC_PAIR_ONE); // [RL5]
    state_d.ctrl_q.internal_ref_sel =
      (state_d.ref_q.ref_source_select == rec_pkg::REC_SRC_INTERNAL); // [RL5]
    state_d.ctrl_q.ref_source_reserved =
      !(state_d.ctrl_q.ext_ref_pair_zero_sel
        || state_d.ctrl_q.ext_ref_pair_one_sel
        || state_d.ctrl_q.internal_ref_sel);

    // internal reference power, reserved code acts as off
    case (state_d.ref_q.internal_ref_control)
      rec_pkg::REC_IREF_ON_PD:  iref_on = !power_down; // [RL6]
      rec_pkg::REC_IREF_ALWAYS: iref_on = 1'b1; // [RL6]
      default:                  iref_on = 1'b0;
    endcase
    state_d.ctrl_q.internal_ref_on = iref_on;

    // excitation register outputs
    state_d.ctrl_q.amp_rail_monitor_enable =
      state_d.exc_q.amp_rail_monitor_enable; // [RL10]
    state_d.ctrl_q.low_side_switch_closed =
      state_d.exc_q.low_side_switch && !power_down; // [RL11]
    state_d.ctrl_q.excitation_source_one_ua = mag_ua; // [RL12] [RL13]
    state_d.ctrl_q.excitation_source_two_ua = mag_ua; // [RL13]

    // advisory flags on host misuse
    state_d.ctrl_q.excitation_without_ref =
      mag_active
      && (state_d.ref_q.internal_ref_control != rec_pkg::REC_IREF_ON_PD)
      && (state_d.ref_q.internal_ref_control != rec_pkg::REC_IREF_ALWAYS); // [RL8]
    state_d.ctrl_q.internal_ref_buffered =
      state_d.ctrl_q.internal_ref_sel
      && !(state_d.ref_q.pos_ref_buffer_bypass
           && state_d.ref_q.neg_ref_buffer_bypass); // [RL7]
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q                              <= '0;
      state_q.ref_q                        <=
        rec_pkg::rec_ref_reg_type'(rec_pkg::REC_REF_RESET); // [RL1]
      state_q.exc_q                        <= {
        rec_pkg::REC_EXC_RESET[rec_pkg::REC_RAIL_BIT],
        rec_pkg::REC_EXC_RESET[rec_pkg::REC_SWITCH_BIT],
        rec_pkg::REC_EXC_RESET[rec_pkg::REC_MAG_MSB:rec_pkg::REC_MAG_LSB]}; // [RL9]
      state_q.ctrl_q.neg_ref_buffer_bypass <=
        rec_pkg::REC_REF_RESET[rec_pkg::REC_NEG_BYP_BIT]; // [RL1]
      state_q.ctrl_q.ext_ref_pair_zero_sel <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign rdata = state_q.rdata_q;
  assign ctrl  = state_q.ctrl_q;

endmodule : rec_config_regs
`default_nettype wire

// [sim/rec_config_checker.sv]
// concurrent checks on the ports of the config register bank
`timescale 1ns/1ps
`default_nettype none
module rec_config_checker (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     clk_en,
  // register port
  input wire rec_pkg::rec_bus_req_type bus_req,
  input wire logic               [7:0] rdata,
  // mode and outputs
  input wire logic                     power_down,
  input wire rec_pkg::rec_ctrl_type    ctrl
);
  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr_ref;
  logic wr_exc;
  assign wr_ref = clk_en && bus_req.wr && bus_req.addr == rec_pkg::REC_REF_ADDR;
  assign wr_exc = clk_en && bus_req.wr && bus_req.addr == rec_pkg::REC_EXC_ADDR;
  a_rdata_idle: assert property ($past(clk_en) && !$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_exc_resv_zero: assert property ($past(clk_en) && $past(bus_req.rd) &&
      $past(bus_req.addr) == rec_pkg::REC_EXC_ADDR |-> rdata[5:4] == 2'h0)
    else $error("reserved excitation bits read nonzero");
  a_cur_equal: assert property (
      ctrl.excitation_source_one_ua == ctrl.excitation_source_two_ua)
    else $error("excitation sources differ");
  a_mon_code: assert property (
      ctrl.ref_high_monitor |-> ctrl.ref_low_monitor && !ctrl.ref_pull_together)
    else $error("high monitor without low monitor");
  a_src_onehot: assert property ($onehot({
      ctrl.ext_ref_pair_zero_sel, ctrl.ext_ref_pair_one_sel,
      ctrl.internal_ref_sel, ctrl.ref_source_reserved}))
    else $error("reference source decode not one-hot");
  a_ref_bypass: assert property (wr_ref |=> {ctrl.pos_ref_buffer_bypass,
      ctrl.neg_ref_buffer_bypass} == $past(bus_req.wdata[5:4]))
    else $error("bypass bits do not follow write");
  a_iref_code: assert property (wr_ref |=>
      ctrl.internal_ref_on == ($past(bus_req.wdata[1:0]) == 2'h2 ||
      ($past(bus_req.wdata[1:0]) == 2'h1 && !$past(power_down))))
    else $error("internal reference state wrong after write");
  a_exc_fields: assert property (wr_exc |=>
      ctrl.amp_rail_monitor_enable == $past(bus_req.wdata[7]) &&
      ctrl.low_side_switch_closed == ($past(bus_req.wdata[6]) && !$past(power_down)))
    else $error("rail or switch does not follow write");
  a_mag_off: assert property (wr_exc &&
      (bus_req.wdata[3:0] == 4'h0 || bus_req.wdata[3:0] > 4'h9)
      |=> ctrl.excitation_source_one_ua == 12'h000)
    else $error("off code gives nonzero current");
  a_switch_pd: assert property (power_down && clk_en |=> !ctrl.low_side_switch_closed)
    else $error("switch closed in power-down");
  // main scenarios reached
  c_pd_write: cover property (wr_exc && power_down);
  c_ref_read: cover property (bus_req.rd && bus_req.addr == rec_pkg::REC_REF_ADDR);
  c_frozen_wr: cover property (bus_req.wr && !clk_en);
endmodule : rec_config_checker
bind rec_config_regs rec_config_checker chk_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
  .bus_req(bus_req), .rdata(rdata), .power_down(power_down), .ctrl(ctrl));
`default_nettype wire

// [sim/rec_host_model.sv]
// host bus master model for the config register bank
`timescale 1ns/1ps
`default_nettype none
module rec_host_model (
  // clock
  input  wire logic                     clock,
  // register port
  output rec_pkg::rec_bus_req_type      bus_req,
  input  wire logic               [7:0] rdata
);
  // ********************************************************
  // bus cycles
  // ********************************************************
  logic raw_ok = 1'b0; // lets a scenario set reserved bits on purpose
  initial bus_req = '0;
  // one-cycle write strobe
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= (a == rec_pkg::REC_EXC_ADDR && !raw_ok) ? (d & 8'hCF) : d;
    @(posedge clock);
    bus_req.wr    <= 1'b0;
    #1;
  endtask : write_reg
  // one-cycle read strobe, data taken in the following cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge clock);
    bus_req.rd   <= 1'b0;
    #1 d = rdata;
  endtask : read_reg
  // internal reference on and both buffers bypassed before any current
  task automatic use_internal(input logic [3:0] mag);
    write_reg(rec_pkg::REC_REF_ADDR, 8'h3A);
    write_reg(rec_pkg::REC_EXC_ADDR, {4'h0, mag});
  endtask : use_internal
endmodule : rec_host_model
`default_nettype wire

// [sim/tb_reference_excitation_config_regs.sv]
// self-checking bench of the config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_reference_excitation_config_regs;
  // ********************************************************
  // stimulus and checks
  // ********************************************************
  logic                     clock      = 1'b0;
  logic                     rst_n      = 1'b0;
  logic                     clk_en     = 1'b1;
  logic                     power_down = 1'b0;
  rec_pkg::rec_bus_req_type bus_req;
  logic               [7:0] rdata;
  rec_pkg::rec_ctrl_type    ctrl;
  int                       num_errors = 0;
  int                       n_compared = 0;
  logic              [11:0] ua_tab [16];
  rec_config_regs dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
    .rdata(rdata), .power_down(power_down), .ctrl(ctrl));
  rec_host_model host_u (.clock(clock), .bus_req(bus_req), .rdata(rdata));
  // free-running clock
  initial forever #4 clock = ~clock;
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_reg(a, d);
    chk("rdata", 12'(d), 12'(exp));
  endtask : rd
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    ua_tab = '{12'h000, 12'h00A, 12'h032, 12'h064, 12'h0FA, 12'h1F4, 12'h2EE, 12'h3E8,
               12'h5DC, 12'h7D0, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h05, 8'h10);
    rd(8'h06, 8'h00);
    chk("ref_rst", 12'({ctrl.neg_ref_buffer_bypass, ctrl.ext_ref_pair_zero_sel}),
        12'h003);
    for (int m = 0; m < 4; m++) begin
      host_u.write_reg(8'h05, 8'(m << 6));
      rd(8'h05, 8'(m << 6));
      chk("mon", 12'({ctrl.ref_low_monitor, ctrl.ref_high_monitor, ctrl.ref_pull_together}),
          {9'h0, m != 0, m == 2, m == 3});
    end
    for (int s = 0; s < 4; s++) begin
      host_u.write_reg(8'h05, 8'(s << 2));
      chk("src", 12'({ctrl.ext_ref_pair_zero_sel, ctrl.ext_ref_pair_one_sel,
          ctrl.internal_ref_sel, ctrl.ref_source_reserved}), 12'(4'h8 >> s));
      chk("ibuf", 12'(ctrl.internal_ref_buffered), 12'(s == 2));
    end
    for (int p = 0; p < 2; p++) begin
      power_down <= p[0];
      for (int c = 0; c < 4; c++) begin
        host_u.write_reg(8'h05, 8'(c));
        chk("iref", 12'(ctrl.internal_ref_on), 12'((c == 1 && p == 0) || c == 2));
      end
    end
    power_down <= 1'b0;
    host_u.write_reg(8'h05, 8'h22);
    chk("bypass", 12'({ctrl.pos_ref_buffer_bypass, ctrl.neg_ref_buffer_bypass}),
        12'h002);
    for (int i = 0; i < 16; i++) begin
      host_u.write_reg(8'h06, 8'(i));
      chk("ua1", ctrl.excitation_source_one_ua, ua_tab[i]);
      chk("ua2", ctrl.excitation_source_two_ua, ua_tab[i]);
    end
    host_u.raw_ok = 1'b1;
    host_u.write_reg(8'h06, 8'hF5);
    host_u.raw_ok = 1'b0;
    rd(8'h06, 8'hC5);
    chk("rail_sw", 12'({ctrl.amp_rail_monitor_enable, ctrl.low_side_switch_closed}),
        12'h003);
    power_down <= 1'b1;
    @(posedge clock);
    #1 chk("sw_pd", 12'({ctrl.amp_rail_monitor_enable, ctrl.low_side_switch_closed}),
           12'h002);
    power_down <= 1'b0;
    host_u.write_reg(8'h06, 8'h00);
    chk("rail_off", 12'(ctrl.amp_rail_monitor_enable), 12'h000);
    host_u.write_reg(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h05, 8'h22);
    clk_en <= 1'b0;
    host_u.write_reg(8'h05, 8'h3A);
    clk_en <= 1'b1;
    rd(8'h05, 8'h22);
    host_u.use_internal(4'h5);
    chk("int_use", 12'({ctrl.internal_ref_buffered, ctrl.excitation_without_ref}),
        12'h000);
    summarize();
  end
endmodule : tb_reference_excitation_config_regs
`default_nettype wire
